// >>> verilog/slmic_pkg.sv
// Constants, register map and types of the serial line status, modem and infrared control block.
// Assumes a single 250 MHz clock domain and an Avalon-MM register port with 32-bit data.
package slmic_pkg;

  // ----------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [31:0] IDX_LINE_STATUS = 32'h0c00_0005;
  localparam logic [31:0] IDX_MODEM_LINE_STATUS = 32'h0c00_0006;
  localparam logic [31:0] IDX_USER_SCRATCH = 32'h0c00_0007;
  localparam logic [31:0] IDX_INFRARED_SELECT = 32'h0c00_0008;
  localparam logic [31:0] IDX_UNIT_SOFT_RESET = 32'h0c00_0009;
  localparam logic [31:0] IDX_FRAME_CTL = 32'h0c00_000c;
  localparam logic [31:0] IDX_SAMPLE_DIV = 32'h0c00_000d;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] IRSEL_MASK = 8'h3f;
  localparam logic [7:0] RESET_MASK = 8'h01;
  localparam logic [7:0] FRAME_MASK = 8'h1f;
  localparam int FRM_FIFO_BIT = 4;
  localparam int FRM_EVEN_BIT = 3;
  localparam int FRM_PAR_BIT = 2;
  localparam logic [7:0] SCRATCH_RST = 8'h00;
  localparam logic [7:0] IRSEL_RST = 8'h00;
  localparam logic [7:0] FRAME_RST = 8'h03;
  localparam logic [7:0] DIV_RST = 8'h00;

  // ----------------------------------------------------------------
  // Receiver timing in sample ticks
  // ----------------------------------------------------------------
  localparam logic [3:0] SMP_MID = 4'h7;
  localparam logic [3:0] SMP_SECOND = 4'hb;
  localparam logic [3:0] SMP_LAST = 4'hf;
  localparam int SMP_PER_BIT_LOG2 = 4;

  typedef enum logic [6:0] {
    RX_IDLE = 7'h01,
    RX_START = 7'h02,
    RX_DATA = 7'h04,
    RX_PARITY = 7'h08,
    RX_STOP = 7'h10,
    RX_HOLD = 7'h20,
    RX_BRKWAIT = 7'h40
  } slmic_rx_state_t;

endpackage : slmic_pkg

// >>> verilog/slmic_core.sv
// Receive-line error detection, modem status, scratch, infrared select and unit reset.
// Assumes the receive queue, transmitter and holding registers sit outside and exchange
// characters, error tags and queue state with this block on the same clock.
//
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/1ps
module slmic_core (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic [31:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic rs232_rx_in,
  input wire logic ir_rx_in,
  input wire logic dcd_n_in,
  input wire logic ri_n_in,
  input wire logic dsr_n_in,
  input wire logic cts_n_in,
  input wire logic tx_serial_in,
  input wire logic fir_tx_in,
  output logic rs232_tx_out,
  output logic ir_tx_out,
  output logic fir_rx_out,
  input wire logic fifo_full_in,
  input wire logic data_ready_in,
  input wire logic tx_empty_in,
  input wire logic thr_empty_in,
  input wire logic head_load_in,
  input wire logic [2:0] head_tags_in,
  output logic rx_push_out,
  output logic [7:0] rx_data_out,
  output logic [2:0] rx_tags_out,
  output logic line_status_read_out,
  output logic fifo_mode_out,
  output logic unit_reset_out,
  output logic module_mode_strobe_out,
  output logic module_speed_select_out,
  output logic [1:0] module_type_field_out,
  output logic infrared_owner_select_out
);

  // ----------------------------------------------------------------
  // Address decode helper
  // ----------------------------------------------------------------
  function automatic logic reg_hit(input logic [31:0] addr, input logic [31:0] idx);
    reg_hit = (addr == {idx[29:0], 2'b00});
  endfunction : reg_hit

  logic srst;
  logic urst;
  logic ack_q;
  logic take;
  logic rd_take;
  logic wr_take;
  logic hit_ls, hit_ms, hit_sc, hit_ir, hit_rs, hit_fr, hit_dv;
  logic [7:0] wdat;
  logic [7:0] rdata_d;
  logic [31:0] rdata_q;

  assign srst = !nrst_in;
  assign take = (avs_read_in || avs_write_in) && !ack_q;
  assign rd_take = take && avs_read_in;
  assign wr_take = take && avs_write_in && avs_byteenable_in[0];
  assign wdat = avs_writedata_in[7:0];
  assign hit_ls = reg_hit(avs_address_in, slmic_pkg::IDX_LINE_STATUS);
  assign hit_ms = reg_hit(avs_address_in, slmic_pkg::IDX_MODEM_LINE_STATUS);
  assign hit_sc = reg_hit(avs_address_in, slmic_pkg::IDX_USER_SCRATCH);
  assign hit_ir = reg_hit(avs_address_in, slmic_pkg::IDX_INFRARED_SELECT);
  assign hit_rs = reg_hit(avs_address_in, slmic_pkg::IDX_UNIT_SOFT_RESET);
  assign hit_fr = reg_hit(avs_address_in, slmic_pkg::IDX_FRAME_CTL);
  assign hit_dv = reg_hit(avs_address_in, slmic_pkg::IDX_SAMPLE_DIV);
  // One wait state: the answer is always ready on the second cycle
  assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack_q;
  assign avs_readdata_out = rdata_q;

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  logic [7:0] scratch_q, irsel_q, frame_q, div_q;
  logic unit_reset_q;

  always_ff @(posedge core_clk_in) begin
    if (srst) begin
      ack_q <= 1'b0;
      scratch_q <= slmic_pkg::SCRATCH_RST;
      irsel_q <= slmic_pkg::IRSEL_RST;
      frame_q <= slmic_pkg::FRAME_RST;
      div_q <= slmic_pkg::DIV_RST;
      unit_reset_q <= 1'b0;
    end else begin
      ack_q <= take;
      if (wr_take && hit_sc) scratch_q <= wdat;
      if (wr_take && hit_ir) irsel_q <= wdat & slmic_pkg::IRSEL_MASK;
      if (wr_take && hit_rs) unit_reset_q <= wdat[0];
      if (wr_take && hit_fr) frame_q <= wdat & slmic_pkg::FRAME_MASK;
      if (wr_take && hit_dv) div_q <= wdat;
    end
  end

  // Soft reset holds the divider, receiver, queue hand-off and status flags but leaves the register port and pin routing usable
  assign urst = srst || unit_reset_q;
  assign unit_reset_out = unit_reset_q;

  logic fifo_mode, par_en, par_even;
  logic [3:0] data_len;
  assign fifo_mode = frame_q[slmic_pkg::FRM_FIFO_BIT];
  assign par_en = frame_q[slmic_pkg::FRM_PAR_BIT];
  assign par_even = frame_q[slmic_pkg::FRM_EVEN_BIT];
  assign data_len = 4'h5 + {2'b00, frame_q[1:0]};
  assign fifo_mode_out = fifo_mode;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] pin_s1_q, pin_s2_q;
  logic [3:0] modem_s3_q;
  logic rx_raw;

  // Receive path follows the owner and path bits; a lent module looks idle
  assign rx_raw = irsel_q[0] ? (irsel_q[1] ? 1'b1 : ir_rx_in) : rs232_rx_in;

  always_ff @(posedge core_clk_in) begin
    if (srst) begin
      pin_s1_q <= 5'h1f;
      pin_s2_q <= 5'h1f;
      modem_s3_q <= 4'hf;
    end else begin
      pin_s1_q <= {rx_raw, dcd_n_in, ri_n_in, dsr_n_in, cts_n_in};
      pin_s2_q <= pin_s1_q;
      modem_s3_q <= pin_s2_q[3:0];
    end
  end

  logic rx_in_s;
  assign rx_in_s = pin_s2_q[4];

  // ----------------------------------------------------------------
  // Pin routing and infrared module control
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (srst) begin
      rs232_tx_out <= 1'b1;
      ir_tx_out <= 1'b1;
      fir_rx_out <= 1'b1;
      module_mode_strobe_out <= 1'b0;
      module_speed_select_out <= 1'b0;
      module_type_field_out <= 2'b00;
      infrared_owner_select_out <= 1'b0;
    end else begin
      rs232_tx_out <= irsel_q[0] ? 1'b1 : tx_serial_in;
      ir_tx_out <= irsel_q[1] ? fir_tx_in : (irsel_q[0] ? tx_serial_in : 1'b1);
      fir_rx_out <= irsel_q[1] ? ir_rx_in : 1'b1;
      module_mode_strobe_out <= irsel_q[5];
      module_speed_select_out <= irsel_q[4];
      module_type_field_out <= irsel_q[3:2];
      infrared_owner_select_out <= irsel_q[1];
    end
  end

  // ----------------------------------------------------------------
  // Sample tick divider, sixteen ticks per bit
  // ----------------------------------------------------------------
  logic [7:0] div_cnt_q;
  logic tick;
  assign tick = (div_cnt_q == 8'h00);

  always_ff @(posedge core_clk_in) begin
    if (urst) div_cnt_q <= 8'h00;
    else div_cnt_q <= tick ? div_q : div_cnt_q - 8'h01;
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  slmic_pkg::slmic_rx_state_t st_q;
  logic [3:0] smp_q, bit_q;
  logic [7:0] sh_q;
  logic par_q, all_low_q, resync_q;
  logic [7:0] low_cnt_q;
  logic [7:0] brk_thr;
  logic [7:0] char_val;
  logic par_fail;
  logic char_done;
  logic [2:0] char_tags;
  logic [7:0] char_data;
  logic mid, last;

  assign mid = tick && (smp_q == slmic_pkg::SMP_MID);
  assign last = tick && (smp_q == slmic_pkg::SMP_LAST);
  // Whole frame: start, data, parity, stop, in sample ticks
  assign brk_thr = 8'({4'h2 + data_len + {3'b000, par_en}, 4'h0});
  assign char_val = sh_q >> (4'h8 - data_len);
  assign par_fail = par_en && ((^char_val ^ par_q) != !par_even);

  // Completion fires on the stop sample, or in hold when the line rises or the low time passes a whole frame
  always_comb begin
    char_done = 1'b0;
    char_tags = 3'b000;
    char_data = char_val;
    if (st_q == slmic_pkg::RX_STOP && mid && (rx_in_s || !all_low_q)) begin
      char_done = 1'b1;
      char_tags = {1'b0, !rx_in_s, par_fail};
    end else if (st_q == slmic_pkg::RX_HOLD && tick) begin
      if (rx_in_s) begin
        char_done = 1'b1;
        char_tags = {1'b0, 1'b1, par_fail};
      end else if (low_cnt_q > brk_thr) begin
        char_done = 1'b1;
        char_tags = 3'b100;
        char_data = 8'h00;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (urst) low_cnt_q <= 8'h00;
    else if (tick) low_cnt_q <= rx_in_s ? 8'h00 : low_cnt_q + {7'h00, low_cnt_q != 8'hff};
  end

  always_ff @(posedge core_clk_in) begin
    if (urst) begin
      st_q <= slmic_pkg::RX_IDLE;
      smp_q <= 4'h0;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      par_q <= 1'b0;
      all_low_q <= 1'b0;
      resync_q <= 1'b0;
    end else if (tick) begin
      smp_q <= smp_q + 4'h1;
      if (!rx_in_s && mid) all_low_q <= all_low_q;
      else if (rx_in_s && mid) all_low_q <= 1'b0;
      unique case (st_q)
        slmic_pkg::RX_IDLE: begin
          smp_q <= 4'h0;
          all_low_q <= 1'b1;
          if (!rx_in_s) st_q <= slmic_pkg::RX_START;
        end
        slmic_pkg::RX_START: begin
          // After a framing error the start bit must be seen low twice
          if (rx_in_s && (mid || (resync_q && smp_q == slmic_pkg::SMP_SECOND))) begin
            st_q <= slmic_pkg::RX_IDLE;
          end else if (last) begin
            st_q <= slmic_pkg::RX_DATA;
            bit_q <= 4'h0;
            resync_q <= 1'b0;
          end
        end
        slmic_pkg::RX_DATA: begin
          if (mid) sh_q <= {rx_in_s, sh_q[7:1]};
          if (last) begin
            bit_q <= bit_q + 4'h1;
            if (bit_q == data_len - 4'h1) begin
              st_q <= par_en ? slmic_pkg::RX_PARITY : slmic_pkg::RX_STOP;
            end
          end
        end
        slmic_pkg::RX_PARITY: begin
          if (mid) par_q <= rx_in_s;
          if (last) st_q <= slmic_pkg::RX_STOP;
        end
        slmic_pkg::RX_STOP: begin
          if (mid) begin
            if (rx_in_s) st_q <= slmic_pkg::RX_IDLE;
            else if (all_low_q) st_q <= slmic_pkg::RX_HOLD;
            else begin
              st_q <= slmic_pkg::RX_IDLE;
              resync_q <= 1'b1;
            end
          end
        end
        slmic_pkg::RX_HOLD: begin
          if (rx_in_s) begin
            st_q <= slmic_pkg::RX_IDLE;
            resync_q <= 1'b1;
          end else if (low_cnt_q > brk_thr) st_q <= slmic_pkg::RX_BRKWAIT;
        end
        slmic_pkg::RX_BRKWAIT: begin
          // Only a return to marking lets a new start bit count
          if (rx_in_s) st_q <= slmic_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Queue hand-off and overrun
  // ----------------------------------------------------------------
  logic ovr_evt, push;
  assign ovr_evt = char_done && (fifo_mode ? fifo_full_in : data_ready_in);
  // A full queue drops the fresh character rather than the oldest one
  assign push = char_done && !(fifo_mode && fifo_full_in);

  always_ff @(posedge core_clk_in) begin
    if (urst) begin
      rx_push_out <= 1'b0;
      rx_data_out <= 8'h00;
      rx_tags_out <= 3'b000;
    end else begin
      rx_push_out <= push;
      if (push) rx_data_out <= char_data;
      if (push) rx_tags_out <= char_tags;
    end
  end

  // ----------------------------------------------------------------
  // Line status flags: set wins over the read clear
  // ----------------------------------------------------------------
  logic [2:0] err_set;
  logic sum_set;
  logic ls_rd, ms_rd;
  logic brk_q, fe_q, pe_q, ovr_q, sum_q;

  assign ls_rd = rd_take && hit_ls;
  assign ms_rd = rd_take && hit_ms;
  assign line_status_read_out = ls_rd;
  assign err_set = fifo_mode ? (head_load_in ? head_tags_in : 3'b000)
                             : (char_done ? char_tags : 3'b000);
  assign sum_set = fifo_mode && head_load_in && (head_tags_in != 3'b000);

  always_ff @(posedge core_clk_in) begin
    if (urst) begin
      brk_q <= 1'b0;
      fe_q <= 1'b0;
      pe_q <= 1'b0;
      ovr_q <= 1'b0;
      sum_q <= 1'b0;
    end else begin
      brk_q <= err_set[2] || (brk_q && !ls_rd);
      fe_q <= err_set[1] || (fe_q && !ls_rd);
      pe_q <= err_set[0] || (pe_q && !ls_rd);
      ovr_q <= ovr_evt || (ovr_q && !ls_rd);
      sum_q <= fifo_mode && (sum_set || (sum_q && !ls_rd));
    end
  end

  // ----------------------------------------------------------------
  // Modem change flags
  // ----------------------------------------------------------------
  logic [3:0] mchg_q;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_mchg
      always_ff @(posedge core_clk_in) begin
        if (urst) mchg_q[gi] <= 1'b0;
        else mchg_q[gi] <= (pin_s2_q[gi] != modem_s3_q[gi]) || (mchg_q[gi] && !ms_rd);
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [7:0] ls_val, ms_val;
  assign ls_val = {sum_q, tx_empty_in, thr_empty_in, brk_q, fe_q, pe_q, ovr_q, data_ready_in};
  assign ms_val = {~pin_s2_q[3:0], mchg_q};

  always_comb begin
    rdata_d = 8'h00;
    if (hit_ls) rdata_d = ls_val;
    else if (hit_ms) rdata_d = ms_val;
    else if (hit_sc) rdata_d = scratch_q;
    else if (hit_ir) rdata_d = irsel_q;
    else if (hit_rs) rdata_d = {7'h00, unit_reset_q};
    else if (hit_fr) rdata_d = frame_q;
    else if (hit_dv) rdata_d = div_q;
  end

  always_ff @(posedge core_clk_in) begin
    if (srst) rdata_q <= 32'h0000_0000;
    else if (rd_take) rdata_q <= {24'h00_0000, rdata_d};
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_sum_fifo_only: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    !fifo_mode |=> !sum_q) else $error("summary flag set outside fifo mode");
  chk_read_clears_ls: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    ls_rd && err_set == 3'b000 && !ovr_evt && !sum_set |=> !brk_q && !fe_q && !pe_q && !ovr_q && !sum_q)
    else $error("line status read did not clear flags");
  chk_break_zero_push: assert property (@(posedge core_clk_in) disable iff (urst)
    char_done && char_tags[2] && !fifo_full_in |=> rx_push_out && rx_data_out == 8'h00
      ##1 st_q == slmic_pkg::RX_BRKWAIT) else $error("break did not push one zero character");
  chk_overrun_drop: assert property (@(posedge core_clk_in) disable iff (urst)
    char_done && fifo_mode && fifo_full_in |=> !rx_push_out && ovr_q)
    else $error("overrun character entered the queue");
  chk_live_levels: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    ms_val[7:4] == ~$past({dcd_n_in, ri_n_in, dsr_n_in, cts_n_in}, 2))
    else $error("modem level bits not inverted inputs");
  chk_change_flag: assert property (@(posedge core_clk_in) disable iff (urst)
    pin_s2_q[0] != modem_s3_q[0] |=> mchg_q[0] ##1 (mchg_q[0] || $past(ms_rd)))
    else $error("change flag lost");
  chk_ms_read_clear: assert property (@(posedge core_clk_in) disable iff (urst)
    ms_rd && pin_s2_q[3:0] == modem_s3_q |=> mchg_q == 4'h0) else $error("change flags kept");
  chk_scratch_hold: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    wr_take && hit_sc |=> scratch_q == $past(wdat) ##1 scratch_q == $past(wdat, 2))
    else $error("scratch did not keep written value");
  chk_unit_reset: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    unit_reset_q |=> st_q == slmic_pkg::RX_IDLE && !rx_push_out) else $error("unit ran in reset");
  chk_path_route: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    irsel_q[0] |=> rs232_tx_out) else $error("serial pins driven while infrared path set");
  chk_answer_bound: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    avs_read_in || avs_write_in |-> ##[0:1] !avs_waitrequest_out) else $error("no bus answer");
  cov_break: cover property (@(posedge core_clk_in) char_done && char_tags[2]);
  cov_frame_err: cover property (@(posedge core_clk_in) char_done && char_tags[1]);
  cov_overrun: cover property (@(posedge core_clk_in) ovr_evt && fifo_mode);
  cov_set_on_clear: cover property (@(posedge core_clk_in) ls_rd && err_set != 3'b000);

endmodule : slmic_core

// >>> sim/slmic_far_model.sv
// Far-side model: serial receive line, modem inputs and infrared module.
// Assumes the bench calls its tasks at a rising edge; one bit lasts 16 clocks.
`timescale 1ns/1ps
module slmic_far_model (
  input wire logic core_clk_in,
  input wire logic mode_strobe_in,
  input wire logic speed_in,
  output logic line_out,
  output logic [3:0] modem_n_out,
  output logic mode_fast_out
);
  // ----------------------------------------
  // Module takes its speed on a rising mode strobe
  // ----------------------------------------
  logic strobe_q = 1'b0;
  initial begin
    line_out = 1'b1;
    modem_n_out = 4'hf;
    mode_fast_out = 1'b0;
  end
  always @(posedge core_clk_in) begin
    strobe_q <= mode_strobe_in;
    if (mode_strobe_in && !strobe_q) begin
      mode_fast_out <= speed_in;
    end
  end
  // Line returns to mark after every frame, so a low stop bit never lingers
  task automatic send(input logic [31:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      line_out <= bits[i];
      repeat (16) @(posedge core_clk_in);
    end
    line_out <= 1'b1;
  endtask : send
  task automatic set_modem(input logic [3:0] v);
    modem_n_out <= v;
  endtask : set_modem
endmodule : slmic_far_model

// >>> sim/tb_top.sv
// Self-checking bench for the line status, modem and infrared control block.
// Assumes divider 0, so one serial bit is 16 clocks.
`timescale 1ns/1ps
module tb_top;
  localparam logic [31:0] LS = slmic_pkg::IDX_LINE_STATUS;
  localparam logic [31:0] MS = slmic_pkg::IDX_MODEM_LINE_STATUS;
  localparam logic [31:0] SC = slmic_pkg::IDX_USER_SCRATCH;
  localparam logic [31:0] IR = slmic_pkg::IDX_INFRARED_SELECT;
  localparam logic [31:0] RS = slmic_pkg::IDX_UNIT_SOFT_RESET;
  localparam logic [31:0] FC = slmic_pkg::IDX_FRAME_CTL;
  logic clk = 1'b0, nrst = 1'b0, rd = 1'b0, wr = 1'b0, wreq, rx, ir_rx = 1'b1, txs = 1'b1;
  logic firtx = 1'b1, ffull = 1'b0, hld = 1'b0, push, lsr_rd, fmode, urst, mstb, mspd;
  logic owner, rs_tx, ir_tx, fir_rx, fast;
  logic [31:0] addr = 32'h0000_0000, wdata = 32'h0000_0000, rdata;
  logic [3:0] modem_n;
  logic [2:0] htags = 3'h0, ptags;
  logic [1:0] mtype;
  logic [7:0] pdata;
  int mismatches = 0, comparisons = 0, pcnt = 0, cyc = 0, n0, lcnt = 0;
  logic [3:0] be = 4'h1;
  logic drdy = 1'b0;
  always #2 clk = ~clk;
  slmic_core i_dut (.core_clk_in(clk), .nrst_in(nrst), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
    .rs232_rx_in(rx), .ir_rx_in(ir_rx), .dcd_n_in(modem_n[3]), .ri_n_in(modem_n[2]),
    .dsr_n_in(modem_n[1]), .cts_n_in(modem_n[0]), .tx_serial_in(txs), .fir_tx_in(firtx),
    .rs232_tx_out(rs_tx), .ir_tx_out(ir_tx), .fir_rx_out(fir_rx), .fifo_full_in(ffull),
    .data_ready_in(drdy), .tx_empty_in(drdy), .thr_empty_in(!drdy), .head_load_in(hld),
    .head_tags_in(htags), .rx_push_out(push), .rx_data_out(pdata), .rx_tags_out(ptags),
    .line_status_read_out(lsr_rd), .fifo_mode_out(fmode), .unit_reset_out(urst),
    .module_mode_strobe_out(mstb), .module_speed_select_out(mspd),
    .module_type_field_out(mtype), .infrared_owner_select_out(owner));
  slmic_far_model i_far (.core_clk_in(clk), .mode_strobe_in(mstb), .speed_in(mspd),
    .line_out(rx), .modem_n_out(modem_n), .mode_fast_out(fast));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (push === 1'b1) pcnt++;
    if (lsr_rd === 1'b1) lcnt++;
    if (cyc == 20000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Request held until waitrequest is sampled low, then released
  task automatic bus(input logic w, input logic [31:0] i, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge clk);
    addr <= {i[29:0], 2'b00};
    rd <= !w;
    wr <= w;
    wdata <= {24'h00_0000, d};
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic wrt(input logic [31:0] i, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, i, d, q);
    repeat (3) @(posedge clk);
  endtask : wrt
  task automatic rdc(input logic [31:0] i, input logic [7:0] m, input logic [7:0] e,
                     input string n);
    logic [7:0] q;
    bus(1'b0, i, 8'h00, q);
    chk(n, q & m, e);
  endtask : rdc
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    rdc(SC, 8'hff, 8'h00, "scratch reset");
    rdc(IR, 8'hff, 8'h00, "irsel reset");
    rdc(32'h0c00_0010, 8'hff, 8'h00, "unmapped");
    wrt(SC, 8'ha5);
    rdc(SC, 8'hff, 8'ha5, "scratch");
    be <= 4'h0;
    wrt(SC, 8'h3c);
    be <= 4'h1;
    rdc(SC, 8'hff, 8'ha5, "scratch masked");
    wrt(RS, 8'hfe);
    rdc(RS, 8'hff, 8'h00, "reset reserved");
    $display("regs done");
  endtask : t_regs
  task automatic t_ir();
    wrt(IR, 8'h10);
    wrt(IR, 8'h34);
    wrt(IR, 8'h04);
    chk("module fast", 8'(fast), 8'h01);
    chk("speed", 8'(mspd), 8'h00);
    chk("type", 8'(mtype), 8'h01);
    wrt(IR, 8'hcb);
    rdc(IR, 8'hff, 8'h0b, "irsel");
    firtx <= 1'b0;
    ir_rx <= 1'b0;
    repeat (3) @(posedge clk);
    chk("ir tx fir", 8'(ir_tx), 8'h00);
    chk("fir rx", 8'(fir_rx), 8'h00);
    ir_rx <= 1'b1;
    wrt(IR, 8'h01);
    txs <= 1'b0;
    repeat (3) @(posedge clk);
    chk("ir tx", 8'(ir_tx), 8'h00);
    chk("rs tx idle", 8'(rs_tx), 8'h01);
    wrt(IR, 8'h00);
    chk("rs tx", 8'(rs_tx), 8'h00);
    txs <= 1'b1;
    $display("infrared done");
  endtask : t_ir
  task automatic t_modem();
    i_far.set_modem(4'h0);
    repeat (8) @(posedge clk);
    rdc(MS, 8'hff, 8'hff, "modem");
    rdc(MS, 8'hff, 8'hf0, "modem reread");
    i_far.set_modem(4'ha);
    repeat (8) @(posedge clk);
    rdc(MS, 8'hff, 8'h5a, "modem mix");
    $display("modem done");
  endtask : t_modem
  task automatic t_errors();
    i_far.send(32'h0000_00aa, 10);
    repeat (40) @(posedge clk);
    chk("frame tags", 8'(ptags), 8'h02);
    rdc(LS, 8'h9e, 8'h08, "framing");
    rdc(LS, 8'h9e, 8'h00, "cleared");
    wrt(FC, 8'h07);
    drdy <= 1'b1;
    n0 = pcnt;
    i_far.send(32'h0000_0602, 11);
    repeat (40) @(posedge clk);
    chk("late char pushes", 8'(pcnt - n0), 8'h01);
    chk("parity data", pdata, 8'h01);
    rdc(LS, 8'hff, 8'h47, "parity");
    drdy <= 1'b0;
    wrt(FC, 8'h0f);
    i_far.send(32'h0000_0602, 11);
    repeat (40) @(posedge clk);
    rdc(LS, 8'h9e, 8'h00, "even parity");
    wrt(FC, 8'h03);
    n0 = pcnt;
    i_far.send(32'h0000_0000, 24);
    repeat (40) @(posedge clk);
    chk("break pushes", 8'(pcnt - n0), 8'h01);
    chk("break data", pdata, 8'h00);
    chk("break tag", 8'(ptags[2]), 8'h01);
    rdc(LS, 8'h90, 8'h10, "break");
    $display("errors done");
  endtask : t_errors
  task automatic t_fifo();
    wrt(FC, 8'h13);
    chk("fifo mode out", 8'(fmode), 8'h01);
    ffull <= 1'b1;
    n0 = pcnt;
    i_far.send(32'h0000_0278, 10);
    repeat (40) @(posedge clk);
    chk("overrun pushes", 8'(pcnt - n0), 8'h00);
    rdc(LS, 8'h9e, 8'h02, "overrun");
    ffull <= 1'b0;
    htags <= 3'b010;
    hld <= 1'b1;
    @(posedge clk);
    hld <= 1'b0;
    repeat (3) @(posedge clk);
    rdc(LS, 8'h9e, 8'h88, "head tag");
    n0 = lcnt;
    rdc(LS, 8'h9e, 8'h00, "summary clear");
    chk("status strobes", 8'(lcnt - n0), 8'h01);
    wrt(FC, 8'h03);
    $display("fifo done");
  endtask : t_fifo
  task automatic t_soft();
    wrt(RS, 8'h01);
    chk("unit reset", 8'(urst), 8'h01);
    rdc(RS, 8'hff, 8'h01, "reset reg");
    n0 = pcnt;
    i_far.send(32'h0000_0278, 10);
    repeat (40) @(posedge clk);
    chk("held pushes", 8'(pcnt - n0), 8'h00);
    wrt(RS, 8'h00);
    chk("released", 8'(urst), 8'h00);
    $display("soft reset done");
  endtask : t_soft
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_ir();
    t_modem();
    t_errors();
    t_fifo();
    t_soft();
    stop_test();
  end
endmodule : tb_top
